// *** logic/nand_host_cfg.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the NAND host controller
// Assumes: 125 MHz clk; one 8-bit NAND device on the pins
// Notes: Definitions only; included by bare name
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH

// Clock and pin timing
`define CLK_PERIOD_NS 8
`define GUARD_SETTLE_NS 100
`define GUARD_CYC ((`GUARD_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_PHASE 4'h6

// Register offsets (word index on the plain port)
`define REG_CMD 4'h0
`define REG_BLOCK 4'h1
`define REG_WPCTRL 4'h2
`define REG_STAT 4'h3
`define REG_ID0 4'h4
`define REG_ID4 4'h8
`define REG_BBT 4'h9
`define REG_IRQ_ST 4'hA
`define REG_IRQ_CLR 4'hB
`define REG_IRQ_EN 4'hC
`define REG_ECC 4'hD

// Field positions
`define CMD_OP_LSB 0
`define WP_ALLOW_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_WP_BIT 1
`define STAT_FAIL_BIT 2
`define STAT_BYTE_LSB 8
`define BBT_SCANNED_LSB 16
`define IRQ_DONE 0
`define IRQ_REFUSED 1
`define IRQ_BAD 2
`define IRQ_REPLACE 3

// Reset values
`define WP_ALLOW_RESET 1'b0
`define IRQ_EN_RESET 4'h0

// Device opcodes and bytes
`define OPC_STATUS 8'h70
`define OPC_ID 8'h90
`define OPC_READ1 8'h00
`define OPC_READ2 8'h30
`define OPC_ERASE1 8'h60
`define OPC_ERASE2 8'hD0
`define ID_ADDR 8'h00
`define MARK_COL_LO 8'h00
`define MARK_COL_HI 8'h08
`define ERASED_BYTE 8'hFF
`define SR_FAIL 0
`define SR_READY 6
`define SR_WP 7

// Correction strength reported to software
`define ECC_BITS 8'h04
`define ECC_SECTOR 16'h0210

`endif

// *** logic/nand_host_pkg.sv ***
// Purpose: Types shared by the NAND host controller and its pin cycle engine
// Assumes: Constants live in nand_host_cfg.svh
// Notes: Types only
package nand_host_pkg;

    typedef enum logic [1:0] {
        OP_STATUS = 2'b00,
        OP_ID = 2'b01,
        OP_SCAN = 2'b10,
        OP_ERASE = 2'b11
    } op_e;

    typedef enum logic [2:0] {
        ACT_CMD = 3'b000,
        ACT_ADDR = 3'b001,
        ACT_READ = 3'b010,
        ACT_TWAIT = 3'b011,
        ACT_BWAIT = 3'b100,
        ACT_END = 3'b101
    } act_e;

    typedef enum logic [1:0] {
        PIN_CMD = 2'b00,
        PIN_ADDR = 2'b01,
        PIN_READ = 2'b10
    } pin_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_GUARD = 3'b001,
        S_STEP = 3'b010,
        S_PIN = 3'b011,
        S_TWAIT = 3'b100,
        S_BWAIT = 3'b101
    } host_e;

    typedef struct packed {
        act_e act;
        logic [7:0] val;
    } step_s;

    typedef struct packed {
        pin_e kind;
        logic [7:0] val;
    } pin_req_s;

    typedef struct packed {
        logic cle;
        logic ale;
        logic we_b;
        logic re_b;
        logic [7:0] io_out;
        logic io_oe_b;
    } pins_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } bus_req_s;

endpackage

// *** logic/nand_pin_cycle.sv ***
// Purpose: One NAND bus cycle (command, address or data read) per request
// Assumes: Requests only while not busy; io and ready/busy pins are asynchronous
// Notes: Each strobe is low for PIN_PHASE cycles then high for PIN_PHASE cycles
`timescale 1ns/1ns
`include "nand_host_cfg.svh"
module nand_pin_cycle (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic req_valid,
    input nand_host_pkg::pin_req_s req,
    input wire logic [7:0] io_in,
    input wire logic rb_b,
    output logic busy,
    output logic done,
    output logic [7:0] rd_byte,
    output logic rb_ready,
    output nand_host_pkg::pins_s pins
);
    typedef struct packed {
        logic busy;
        logic [3:0] cnt;
        nand_host_pkg::pins_s pins;
        logic [7:0] rd_byte;
        logic done;
        logic [7:0] io_s1;
        logic [7:0] io_s2;
        logic rb_s1;
        logic rb_s2;
    } eng_s;

    eng_s q_ff;
    eng_s nxt_q;

    // Strobe sequencing; data is sampled at the last low cycle of the read strobe
    always_comb begin
        nxt_q = q_ff;
        nxt_q.done = 1'b0;
        nxt_q.io_s1 = io_in;
        nxt_q.io_s2 = q_ff.io_s1;
        nxt_q.rb_s1 = rb_b;
        nxt_q.rb_s2 = q_ff.rb_s1;
        if (!q_ff.busy) begin
            if (req_valid) begin
                nxt_q.busy = 1'b1;
                nxt_q.cnt = 4'h0;
                nxt_q.pins.cle = (req.kind == nand_host_pkg::PIN_CMD);
                nxt_q.pins.ale = (req.kind == nand_host_pkg::PIN_ADDR);
                nxt_q.pins.we_b = (req.kind == nand_host_pkg::PIN_READ);
                nxt_q.pins.re_b = (req.kind != nand_host_pkg::PIN_READ);
                nxt_q.pins.io_out = req.val;
                nxt_q.pins.io_oe_b = (req.kind == nand_host_pkg::PIN_READ);
            end
        end else if (q_ff.cnt == `PIN_PHASE - 4'h1) begin
            // Synchronised data is two cycles old; low phase covers access time plus that
            if (!q_ff.pins.re_b) begin
                nxt_q.rd_byte = q_ff.io_s2;
            end
            nxt_q.pins.we_b = 1'b1;
            nxt_q.pins.re_b = 1'b1;
            nxt_q.cnt = q_ff.cnt + 4'h1;
        end else if (q_ff.cnt == (`PIN_PHASE << 1) - 4'h1) begin
            // Latches and data held through the high phase for hold time
            nxt_q.busy = 1'b0;
            nxt_q.done = 1'b1;
            nxt_q.pins.cle = 1'b0;
            nxt_q.pins.ale = 1'b0;
            nxt_q.pins.io_oe_b = 1'b1;
        end else begin
            nxt_q.cnt = q_ff.cnt + 4'h1;
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_ff <= '{busy: 1'b0, cnt: 4'h0,
                      pins: '{cle: 1'b0, ale: 1'b0, we_b: 1'b1, re_b: 1'b1,
                              io_out: 8'h00, io_oe_b: 1'b1},
                      rd_byte: 8'h00, done: 1'b0, io_s1: 8'h00, io_s2: 8'h00,
                      rb_s1: 1'b0, rb_s2: 1'b0};
        end else if (ce) begin
            q_ff <= nxt_q;
        end
    end

    assign busy = q_ff.busy;
    assign done = q_ff.done;
    assign rd_byte = q_ff.rd_byte;
    assign rb_ready = q_ff.rb_s2;
    assign pins = q_ff.pins;
endmodule

// *** logic/nand_host.sv ***
// Functional notes
// - Non-erased marker at column 2048 means bad
// - Scan markers before any erase of block
// - Replace block after program or erase failure; code has no program, flags erase failure only
// - Record failed block, never erase it again
// - Read data needs 4-bit per 528-byte ECC
//
// Purpose: Host controller driving a NAND device for status, identifier,
//          bad-block scan and erase, with a bad-block table of 16 blocks
// Assumes: Software on a plain register port; device on asynchronous pins
// Notes: Data copying for block replacement is left to software
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "nand_host_cfg.svh"
module nand_host (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input nand_host_pkg::bus_req_s bus,
    output logic [31:0] rd_data,
    output logic irq,
    output nand_host_pkg::pins_s pins,
    output logic ce_b,
    output logic wp_b,
    input wire logic [7:0] io_in,
    input wire logic rb_b
);
    localparam logic [7:0] GUARD_CYC = 8'(`GUARD_CYC);

    typedef struct packed {
        nand_host_pkg::host_e st;
        nand_host_pkg::op_e op;
        logic [3:0] idx;
        logic page;
        logic [3:0] blk;
        logic [7:0] cnt;
        logic wp_allow;
        logic fail;
        logic [7:0] status;
        logic [4:0][7:0] id;
        logic [15:0] bad;
        logic [15:0] scanned;
        logic [3:0] irq_st;
        logic [3:0] irq_en;
        logic [31:0] rdata;
        logic ce_b;
    } host_s;

    host_s q_ff;
    host_s nxt_q;
    nand_host_pkg::step_s step;
    nand_host_pkg::pin_req_s preq;
    logic preq_valid;
    logic eng_busy;
    logic eng_done;
    logic [7:0] eng_byte;
    logic rb_ready;
    logic [3:0] ev;
    logic [3:0] id_pos;
    logic [9:0] row;

    // Row address: block in the upper bits, page 0 or 1 below
    assign row = {q_ff.blk, 5'h00, q_ff.page};
    assign id_pos = q_ff.idx - 4'h3;

    // Per-operation step table
    always_comb begin
        step = '{act: nand_host_pkg::ACT_END, val: 8'h00};
        unique case (q_ff.op)
            nand_host_pkg::OP_STATUS: begin
                if (q_ff.idx == 4'h0) step = '{nand_host_pkg::ACT_CMD, `OPC_STATUS};
                else if (q_ff.idx == 4'h1) step = '{nand_host_pkg::ACT_TWAIT, 8'h00};
                else if (q_ff.idx == 4'h2) step = '{nand_host_pkg::ACT_READ, 8'h00};
            end
            nand_host_pkg::OP_ID: begin
                if (q_ff.idx == 4'h0) step = '{nand_host_pkg::ACT_CMD, `OPC_ID};
                else if (q_ff.idx == 4'h1) step = '{nand_host_pkg::ACT_ADDR, `ID_ADDR};
                else if (q_ff.idx == 4'h2) step = '{nand_host_pkg::ACT_TWAIT, 8'h00};
                else if (q_ff.idx <= 4'h7) step = '{nand_host_pkg::ACT_READ, 8'h00};
            end
            nand_host_pkg::OP_SCAN: begin
                unique case (q_ff.idx)
                    4'h0: step = '{nand_host_pkg::ACT_CMD, `OPC_READ1};
                    4'h1: step = '{nand_host_pkg::ACT_ADDR, `MARK_COL_LO};
                    4'h2: step = '{nand_host_pkg::ACT_ADDR, `MARK_COL_HI};
                    4'h3: step = '{nand_host_pkg::ACT_ADDR, row[7:0]};
                    4'h4: step = '{nand_host_pkg::ACT_ADDR, {6'h00, row[9:8]}};
                    4'h5: step = '{nand_host_pkg::ACT_ADDR, 8'h00};
                    4'h6: step = '{nand_host_pkg::ACT_CMD, `OPC_READ2};
                    4'h7: step = '{nand_host_pkg::ACT_BWAIT, 8'h00};
                    4'h8: step = '{nand_host_pkg::ACT_READ, 8'h00};
                    default: step = '{nand_host_pkg::ACT_END, 8'h00};
                endcase
            end
            nand_host_pkg::OP_ERASE: begin
                unique case (q_ff.idx)
                    4'h0: step = '{nand_host_pkg::ACT_CMD, `OPC_ERASE1};
                    4'h1: step = '{nand_host_pkg::ACT_ADDR, row[7:0]};
                    4'h2: step = '{nand_host_pkg::ACT_ADDR, {6'h00, row[9:8]}};
                    4'h3: step = '{nand_host_pkg::ACT_ADDR, 8'h00};
                    4'h4: step = '{nand_host_pkg::ACT_CMD, `OPC_ERASE2};
                    4'h5: step = '{nand_host_pkg::ACT_BWAIT, 8'h00};
                    4'h6: step = '{nand_host_pkg::ACT_CMD, `OPC_STATUS};
                    4'h7: step = '{nand_host_pkg::ACT_TWAIT, 8'h00};
                    4'h8: step = '{nand_host_pkg::ACT_READ, 8'h00};
                    default: step = '{nand_host_pkg::ACT_END, 8'h00};
                endcase
            end
        endcase
    end

    // Pin request for command, address and read steps
    always_comb begin
        preq_valid = (q_ff.st == nand_host_pkg::S_STEP) && !eng_busy &&
                     (step.act == nand_host_pkg::ACT_CMD ||
                      step.act == nand_host_pkg::ACT_ADDR ||
                      step.act == nand_host_pkg::ACT_READ);
        preq.val = step.val;
        if (step.act == nand_host_pkg::ACT_CMD) preq.kind = nand_host_pkg::PIN_CMD;
        else if (step.act == nand_host_pkg::ACT_ADDR) preq.kind = nand_host_pkg::PIN_ADDR;
        else preq.kind = nand_host_pkg::PIN_READ;
    end

    nand_pin_cycle u_pin (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .req_valid(preq_valid),
        .req(preq),
        .io_in(io_in),
        .rb_b(rb_b),
        .busy(eng_busy),
        .done(eng_done),
        .rd_byte(eng_byte),
        .rb_ready(rb_ready),
        .pins(pins)
    );

    // Sequencer, bad-block table, register port and interrupt status
    always_comb begin
        nxt_q = q_ff;
        ev = 4'h0;
        nxt_q.rdata = 32'h0000_0000;
        unique case (q_ff.st)
            nand_host_pkg::S_IDLE: begin
                if (bus.wr && bus.addr == `REG_CMD) begin
                    nxt_q.op = nand_host_pkg::op_e'(bus.wdata[`CMD_OP_LSB +: 2]);
                    nxt_q.idx = 4'h0;
                    nxt_q.page = 1'b0;
                    nxt_q.cnt = GUARD_CYC;
                    if (nxt_q.op == nand_host_pkg::OP_ERASE &&
                        (!q_ff.scanned[q_ff.blk] || q_ff.bad[q_ff.blk])) begin
                        ev[`IRQ_REFUSED] = 1'b1;
                    end else begin
                        nxt_q.st = nand_host_pkg::S_GUARD;
                        nxt_q.ce_b = 1'b0;
                        nxt_q.fail = 1'b0;
                    end
                end
            end
            nand_host_pkg::S_GUARD: begin
                // Settle time after a protect change or previous read cycle
                if (q_ff.cnt == 8'h00) nxt_q.st = nand_host_pkg::S_STEP;
                else nxt_q.cnt = q_ff.cnt - 8'h01;
            end
            nand_host_pkg::S_STEP: begin
                nxt_q.cnt = GUARD_CYC;
                if (preq_valid) begin
                    nxt_q.st = nand_host_pkg::S_PIN;
                end else if (step.act == nand_host_pkg::ACT_TWAIT) begin
                    nxt_q.st = nand_host_pkg::S_TWAIT;
                end else if (step.act == nand_host_pkg::ACT_BWAIT) begin
                    nxt_q.st = nand_host_pkg::S_BWAIT;
                end else if (step.act == nand_host_pkg::ACT_END) begin
                    if (q_ff.op == nand_host_pkg::OP_SCAN && !q_ff.page) begin
                        nxt_q.page = 1'b1;
                        nxt_q.idx = 4'h0;
                    end else begin
                        if (q_ff.op == nand_host_pkg::OP_SCAN) nxt_q.scanned[q_ff.blk] = 1'b1;
                        nxt_q.st = nand_host_pkg::S_IDLE;
                        nxt_q.ce_b = 1'b1;
                        ev[`IRQ_DONE] = 1'b1;
                    end
                end
            end
            nand_host_pkg::S_PIN: begin
                if (eng_done) begin
                    nxt_q.idx = q_ff.idx + 4'h1;
                    nxt_q.st = nand_host_pkg::S_STEP;
                    if (step.act == nand_host_pkg::ACT_READ) begin
                        unique case (q_ff.op)
                            nand_host_pkg::OP_STATUS: nxt_q.status = eng_byte;
                            nand_host_pkg::OP_ID: nxt_q.id[id_pos[2:0]] = eng_byte;
                            nand_host_pkg::OP_SCAN: begin
                                if (eng_byte != `ERASED_BYTE) begin
                                    nxt_q.bad[q_ff.blk] = 1'b1;
                                    ev[`IRQ_BAD] = 1'b1;
                                end
                            end
                            nand_host_pkg::OP_ERASE: begin
                                nxt_q.status = eng_byte;
                                if (eng_byte[`SR_FAIL]) begin
                                    nxt_q.fail = 1'b1;
                                    nxt_q.bad[q_ff.blk] = 1'b1;
                                    ev[`IRQ_REPLACE] = 1'b1;
                                end
                            end
                        endcase
                    end
                end
            end
            nand_host_pkg::S_TWAIT: begin
                // Step past the wait, else the same wait step would repeat forever
                if (q_ff.cnt == 8'h00) begin
                    nxt_q.st = nand_host_pkg::S_STEP;
                    nxt_q.idx = q_ff.idx + 4'h1;
                end else begin
                    nxt_q.cnt = q_ff.cnt - 8'h01;
                end
            end
            nand_host_pkg::S_BWAIT: begin
                // Busy shows only after a delay, so ready is ignored until the count ends
                if (q_ff.cnt != 8'h00) begin
                    nxt_q.cnt = q_ff.cnt - 8'h01;
                end else if (rb_ready) begin
                    nxt_q.st = nand_host_pkg::S_STEP;
                    nxt_q.idx = q_ff.idx + 4'h1;
                end
            end
            default: nxt_q.st = nand_host_pkg::S_IDLE;
        endcase
        // Register writes; block select is frozen while an operation runs
        if (bus.wr) begin
            if (bus.addr == `REG_BLOCK && q_ff.st == nand_host_pkg::S_IDLE)
                nxt_q.blk = bus.wdata[3:0];
            if (bus.addr == `REG_WPCTRL) nxt_q.wp_allow = bus.wdata[`WP_ALLOW_BIT];
            if (bus.addr == `REG_IRQ_EN) nxt_q.irq_en = bus.wdata[3:0];
        end
        // Set wins over a clear in the same cycle
        nxt_q.irq_st = q_ff.irq_st & ~((bus.wr && bus.addr == `REG_IRQ_CLR) ?
                                       bus.wdata[3:0] : 4'h0);
        nxt_q.irq_st = nxt_q.irq_st | ev;
        if (bus.rd) begin
            if (bus.addr == `REG_STAT) begin
                nxt_q.rdata[`STAT_BUSY_BIT] = (q_ff.st != nand_host_pkg::S_IDLE);
                nxt_q.rdata[`STAT_WP_BIT] = q_ff.wp_allow;
                nxt_q.rdata[`STAT_FAIL_BIT] = q_ff.fail;
                nxt_q.rdata[`STAT_BYTE_LSB +: 8] = q_ff.status;
            end else if (bus.addr >= `REG_ID0 && bus.addr <= `REG_ID4) begin
                nxt_q.rdata[7:0] = q_ff.id[3'(bus.addr - `REG_ID0)];
            end else if (bus.addr == `REG_BBT) begin
                nxt_q.rdata = {q_ff.scanned, q_ff.bad};
            end else if (bus.addr == `REG_IRQ_ST) begin
                nxt_q.rdata[3:0] = q_ff.irq_st;
            end else if (bus.addr == `REG_IRQ_EN) begin
                nxt_q.rdata[3:0] = q_ff.irq_en;
            end else if (bus.addr == `REG_ECC) begin
                nxt_q.rdata = {`ECC_SECTOR, 8'h00, `ECC_BITS};
            end
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_ff <= '{st: nand_host_pkg::S_IDLE, op: nand_host_pkg::OP_STATUS,
                      idx: 4'h0, page: 1'b0, blk: 4'h0, cnt: 8'h00,
                      wp_allow: `WP_ALLOW_RESET, fail: 1'b0, status: 8'h00,
                      id: '0, bad: 16'h0000, scanned: 16'h0000, irq_st: 4'h0,
                      irq_en: `IRQ_EN_RESET, rdata: 32'h0000_0000, ce_b: 1'b1};
        end else if (ce) begin
            q_ff <= nxt_q;
        end
    end

    assign rd_data = q_ff.rdata;
    assign irq = |(q_ff.irq_st & q_ff.irq_en);
    assign ce_b = q_ff.ce_b;
    assign wp_b = q_ff.wp_allow;

    // Checks
    sequence id_cmd_s;
        preq_valid && preq.kind == nand_host_pkg::PIN_CMD && preq.val == `OPC_ID;
    endsequence
    sequence zero_addr_s;
        preq_valid && preq.kind == nand_host_pkg::PIN_ADDR && preq.val == `ID_ADDR;
    endsequence

    id_zero_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
        id_cmd_s |-> ##[2:40] zero_addr_s)
        else $error("identifier command not followed by zero address");

    erase_scanned_a: assert property (@(posedge clk) disable iff (!rst_b)
        preq_valid && preq.kind == nand_host_pkg::PIN_CMD && preq.val == `OPC_ERASE1
        |-> q_ff.scanned[q_ff.blk])
        else $error("erase issued to an unscanned block");

    marker_bad_a: assert property (@(posedge clk) disable iff (!rst_b || !ce)
        q_ff.st == nand_host_pkg::S_PIN && eng_done && q_ff.op == nand_host_pkg::OP_SCAN &&
        step.act == nand_host_pkg::ACT_READ && eng_byte != `ERASED_BYTE
        |=> q_ff.bad[q_ff.blk] && q_ff.irq_st[`IRQ_BAD])
        else $error("non-erased marker not recorded as bad");

    fail_replace_a: assert property (@(posedge clk) disable iff (!rst_b || !ce)
        q_ff.st == nand_host_pkg::S_PIN && eng_done && q_ff.op == nand_host_pkg::OP_ERASE &&
        step.act == nand_host_pkg::ACT_READ && eng_byte[`SR_FAIL]
        |=> q_ff.irq_st[`IRQ_REPLACE] && q_ff.fail)
        else $error("erase failure did not request replacement");

    bad_erase_a: assert property (@(posedge clk) disable iff (!rst_b)
        preq_valid && preq.val == `OPC_ERASE2 && preq.kind == nand_host_pkg::PIN_CMD
        |-> !q_ff.bad[q_ff.blk] && q_ff.op == nand_host_pkg::OP_ERASE)
        else $error("erase confirmed on a recorded bad block");

    ecc_report_a: assert property (@(posedge clk) disable iff (!rst_b || !ce)
        bus.rd && bus.addr == `REG_ECC ##1 1'b1 |-> rd_data[7:0] == `ECC_BITS)
        else $error("correction strength misreported");
endmodule

// *** verif/nand_dev_model.sv ***
// Purpose: Behavioural NAND device on the host pins
// Assumes: One device, 8-bit io, pull-up on ready/busy
// Notes: Marker and erase fault maps are parameters
`timescale 1ns/1ns
module nand_dev_model #(
    parameter logic [39:0] ID_BYTES = 40'h12_34_56_78_9A, // Arbitrary identifier values
    parameter logic [15:0] BAD_P0 = 16'h0002,
    parameter logic [15:0] BAD_P1 = 16'h0004,
    parameter logic [15:0] FAIL_BLK = 16'h0008,
    parameter int BUSY_NS = 800
) (
    input nand_host_pkg::pins_s pins,
    input wire logic ce_b,
    input wire logic wp_b,
    output logic [7:0] io_in,
    output logic rb_b
);
    logic [7:0] cmd = 8'h00;
    logic [7:0] q = 8'h00;
    logic [7:0] a0 = 8'h00;
    logic [7:0] a1 = 8'h00;
    logic [7:0] a2 = 8'h00;
    logic busy = 1'b0;
    logic fail = 1'b0;
    int idx = 0;
    logic [3:0] blk;
    assign blk = {a1[1:0], a2[7:6]};
    // Released io shows the last byte while re_b is low and its inverse while re_b is high, never a stale copy
    assign io_in = !pins.io_oe_b ? pins.io_out : (pins.re_b ? ~q : q);
    assign rb_b = !busy;
    // Latch commands and address bytes on rising write strobe
    always @(posedge pins.we_b) begin
        if (!ce_b && pins.cle) begin
            cmd = pins.io_out;
            idx = 0;
        end else if (!ce_b && pins.ale) begin
            a2 = a1;
            a1 = a0;
            a0 = pins.io_out;
        end
    end
    always @(posedge pins.we_b) begin
        if (!ce_b && pins.cle && (pins.io_out == 8'h30 || pins.io_out == 8'hD0)) begin
            if (pins.io_out == 8'hD0)
                fail = !wp_b || FAIL_BLK[blk];
            busy = 1'b1;
            #(BUSY_NS) busy = 1'b0;
        end
    end
    // output bytes; page data survive failures
    always @(negedge pins.re_b) begin
        if (!ce_b) begin
            case (cmd)
                8'h70: q = {wp_b, !busy, 5'h00, fail};
                8'h90: q = ID_BYTES[39 - 8 * idx -: 8];
                default: q = (a2[0] ? BAD_P1[blk] : BAD_P0[blk]) ? 8'h00 : 8'hFF;
            endcase
            idx = idx + 1;
        end
    end
endmodule

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the NAND host controller
// Assumes: Device model on the pins; clock enable held high
// Notes: Polls status until idle under a bounded count
`timescale 1ns/1ns
`include "nand_host_cfg.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    nand_host_pkg::bus_req_s bus = '0;
    logic [31:0] rd_data;
    logic irq;
    nand_host_pkg::pins_s pins;
    logic ce_b;
    logic wp_b;
    logic [7:0] io_in;
    logic rb_b;
    logic [31:0] d;
    int failures = 0;
    int total_checks = 0;
    // 125 MHz clock
    always #4 clk = ~clk;
    nand_host DUT (.clk(clk), .rst_b(rst_b), .ce(1'b1), .bus(bus), .rd_data(rd_data),
        .irq(irq), .pins(pins), .ce_b(ce_b), .wp_b(wp_b), .io_in(io_in), .rb_b(rb_b));
    nand_dev_model dev (.pins(pins), .ce_b(ce_b), .wp_b(wp_b), .io_in(io_in), .rb_b(rb_b));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        bus <= '{1'b1, 1'b0, a, v};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic op(input logic [3:0] b, input logic [1:0] k);
        int n;
        wr(`REG_BLOCK, {28'h0000000, b});
        wr(`REG_CMD, {30'h00000000, k});
        n = 0;
        rd(`REG_STAT);
        while (d[`STAT_BUSY_BIT] !== 1'b0 && n < 3000) begin
            rd(`REG_STAT);
            n++;
        end
        if (n == 3000)
            chk(32'h1, 32'h0);
    endtask
    task automatic t_reset;
        chk({29'h0, wp_b, ce_b, irq}, 32'h0000_0002);
        rd(`REG_ECC);
        chk(d, 32'h0210_0004);
        rd(4'hF);
        chk(d, 32'h0000_0000);
    endtask
    task automatic t_status;
        op(4'h0, nand_host_pkg::OP_STATUS);
        chk(d, 32'h0000_4000);
        wr(`REG_WPCTRL, 32'h0000_0001);
        op(4'h0, nand_host_pkg::OP_STATUS);
        chk(d, 32'h0000_C002);
    endtask
    task automatic t_id;
        op(4'h0, nand_host_pkg::OP_ID);
        for (int i = 0; i < 5; i++) begin
            rd(4'(`REG_ID0 + i));
            chk(d, {24'h0, dev.ID_BYTES[39 - 8 * i -: 8]});
        end
    endtask
    task automatic t_scan;
        for (int b = 0; b < 4; b++)
            op(4'(b), nand_host_pkg::OP_SCAN);
        rd(`REG_BBT);
        chk(d, 32'h000F_0006);
    endtask
    // Refused erases, then a worn block, then protect low
    task automatic t_erase;
        wr(`REG_IRQ_CLR, 32'h0000_000F);
        wr(`REG_IRQ_EN, 32'h0000_0002);
        op(4'h5, nand_host_pkg::OP_ERASE);
        op(4'h1, nand_host_pkg::OP_ERASE);
        rd(`REG_IRQ_ST);
        chk({30'h0, d[1], irq}, 32'h0000_0003);
        wr(`REG_IRQ_CLR, 32'h0000_0002);
        rd(`REG_IRQ_ST);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(`REG_IRQ_EN, 32'h0000_0008);
        rd(`REG_IRQ_EN);
        chk(d, 32'h0000_0008);
        op(4'h3, nand_host_pkg::OP_ERASE);
        chk(d, 32'h0000_C106);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(`REG_BBT);
        chk(d, 32'h000F_000E);
        op(4'h0, nand_host_pkg::OP_ERASE);
        chk(d, 32'h0000_C002);
        wr(`REG_WPCTRL, 32'h0000_0000);
        op(4'h0, nand_host_pkg::OP_ERASE);
        chk(d, 32'h0000_4104);
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_status();
        t_id();
        t_scan();
        t_erase();
        end_of_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        #600000;
        failures++;
        end_of_test();
    end
endmodule
